// [rtl/sar_adc_digital_interface.sv]
// Purpose: Sequencer, successive-approximation register and output stage of a 12-bit converter.
// Assumes: All inputs are synchronous to clk_sys; comparator decision is valid at the end of each bit cycle.
// Notes:   Output words pass through a two-entry buffer so that a stalled receiver loses no word.
//
// Behaviour
// - Converter runs only while the active-high enable is high.
// - Tracking starts on the first rising edge after enable rises.
// - Next edge samples the input and starts the conversion.
// - Finished result loads the output word with the completion strobe.
// - Completion strobe is active high and marks a fresh valid word.
// - Result is a 12-bit straight unsigned binary, non-inverted code.
// - First select high with the second low makes the inverting input the single-ended input.
// - Second select high with the first low makes the non-inverting input the single-ended input.
// - Both selects low treat the two inputs as a differential pair.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_digital_interface (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic                       enable,
  input  wire logic                       neg_input_single_sel,
  input  wire logic                       pos_input_single_sel,
  input  wire logic                       comp_in,
  input  wire logic                       out_ready,
  output var  logic                       track_out,
  output var  logic                       sample_out,
  output var  sar_adc_pkg::input_mode_type input_mode,
  output var  logic [11:0]                dac_code,
  output var  logic [11:0]                result_word,
  output var  logic                       data_ready,
  output var  logic                       buffer_full
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  sar_adc_pkg::seq_state_type state;
  sar_adc_pkg::seq_state_type next_state;
  logic [3:0]                 bit_idx;
  logic                       buf_ready;
  logic                       push;
  logic                       pop;
  logic                       last_bit;
  logic [11:0]                bit_mask;
  logic [11:0]                lower_mask;
  logic [11:0]                kept_code;
  logic [11:0]                next_trial;

  assign last_bit   = (bit_idx == 4'h0);
  assign bit_mask   = 12'h001 << bit_idx;
  assign lower_mask = 12'h001 << (bit_idx - 4'h1);
  // A comparator high means the input is at or above the trial, so the bit stays set.
  assign kept_code  = comp_in ? dac_code : (dac_code & ~bit_mask);
  assign next_trial = last_bit ? kept_code : (kept_code | lower_mask);
  assign push       = (state == sar_adc_pkg::ST_LOAD) && buf_ready && enable;

  always_comb begin
    next_state = state;
    unique case (state)
      sar_adc_pkg::ST_IDLE:    next_state = sar_adc_pkg::ST_TRACK;
      sar_adc_pkg::ST_TRACK:   next_state = sar_adc_pkg::ST_SAMPLE;
      sar_adc_pkg::ST_SAMPLE:  next_state = sar_adc_pkg::ST_CONVERT;
      sar_adc_pkg::ST_CONVERT: next_state = last_bit ? sar_adc_pkg::ST_LOAD : sar_adc_pkg::ST_CONVERT;
      sar_adc_pkg::ST_LOAD:    next_state = buf_ready ? sar_adc_pkg::ST_RESTORE : sar_adc_pkg::ST_LOAD;
      sar_adc_pkg::ST_RESTORE: next_state = sar_adc_pkg::ST_TRACK;
      default:                 next_state = sar_adc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !enable) begin
      state <= sar_adc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      track_out  <= 1'b0;
      sample_out <= 1'b0;
    end else begin
      track_out  <= enable && (next_state == sar_adc_pkg::ST_TRACK);
      sample_out <= enable && (next_state == sar_adc_pkg::ST_SAMPLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input mode and successive approximation.

  // mode decode.
  // An illegal pair of selects falls back to differential operation.
  sar_adc_pkg::input_mode_type next_mode;
  assign next_mode.neg_single   = neg_input_single_sel && !pos_input_single_sel;
  assign next_mode.pos_single   = pos_input_single_sel && !neg_input_single_sel;
  assign next_mode.differential = !(next_mode.neg_single || next_mode.pos_single);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      input_mode <= sar_adc_pkg::MODE_RESET;
    end else if (state == sar_adc_pkg::ST_TRACK) begin
      input_mode <= next_mode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dac_code <= sar_adc_pkg::RESULT_RESET;
      bit_idx  <= sar_adc_pkg::MSB_INDEX;
    end else if (state == sar_adc_pkg::ST_SAMPLE) begin
      dac_code <= sar_adc_pkg::FIRST_TRIAL;
      bit_idx  <= sar_adc_pkg::MSB_INDEX;
    end else if (state == sar_adc_pkg::ST_CONVERT) begin
      dac_code <= next_trial;
      bit_idx  <= last_bit ? 4'h0 : bit_idx - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; a full buffer holds the sequencer in its load state.

  sar_adc_pkg::sample_word_type buf_mem [sar_adc_pkg::BUF_DEPTH];
  logic                         wr_ptr;
  logic                         rd_ptr;
  logic [1:0]                   count;

  assign buf_ready = (count != sar_adc_pkg::COUNT_FULL);
  assign pop       = (count != sar_adc_pkg::COUNT_RESET) && out_ready;

  genvar g;
  generate
    for (g = 0; g < sar_adc_pkg::BUF_DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          buf_mem[g] <= sar_adc_pkg::RESULT_RESET;
        end else if (push && (wr_ptr == 1'(g))) begin
          buf_mem[g] <= dac_code;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= sar_adc_pkg::COUNT_RESET;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      result_word <= sar_adc_pkg::RESULT_RESET;
      data_ready  <= 1'b0;
      buffer_full <= 1'b0;
    end else begin
      if (pop) begin
        result_word <= buf_mem[rd_ptr].code;
      end
      data_ready  <= pop;
      buffer_full <= (count + {1'b0, push} - {1'b0, pop}) == sar_adc_pkg::COUNT_FULL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_disable_idle: assert property (!enable |=> !track_out && !sample_out && state == sar_adc_pkg::ST_IDLE)
    else $error("Converter active while enable is low.");
  chk_track_after_enable: assert property (enable && state == sar_adc_pkg::ST_IDLE |=> track_out)
    else $error("Tracking did not begin on the edge after enable.");
  chk_sample_follows_track: assert property (track_out && enable |=> sample_out ##1 dac_code == 12'h800)
    else $error("Sample or first trial did not follow tracking.");
  chk_bit_kept_high: assert property (state == sar_adc_pkg::ST_CONVERT && comp_in |=> (dac_code & $past(bit_mask)) != 12'h000)
    else $error("Comparator high did not keep the trial bit.");
  chk_word_with_strobe: assert property (pop |=> data_ready && result_word == $past(buf_mem[rd_ptr].code))
    else $error("Output word and strobe did not update together.");
  chk_strobe_is_taken: assert property (data_ready |-> $past(out_ready) && $past(count) != 2'h0)
    else $error("Strobe raised without a buffered word.");
  chk_mode_neg_single: assert property (state == sar_adc_pkg::ST_TRACK
                                        && neg_input_single_sel && !pos_input_single_sel
                                        |=> input_mode.neg_single && !input_mode.differential)
    else $error("Inverting single-ended mode not selected.");
  chk_mode_pos_single: assert property (state == sar_adc_pkg::ST_TRACK
                                        && pos_input_single_sel && !neg_input_single_sel
                                        |=> input_mode.pos_single && !input_mode.differential)
    else $error("Non-inverting single-ended mode not selected.");
  chk_mode_differential: assert property (state == sar_adc_pkg::ST_TRACK
                                          && !pos_input_single_sel && !neg_input_single_sel
                                          |=> input_mode.differential)
    else $error("Differential mode not selected.");
  // Dropping enable on the load edge legally ends a run, so enable must still be high there.
  chk_frame_period: assert property (push ##1 (enable && buf_ready)[*8]
                                     ##1 (enable && buf_ready)[*7] ##1 enable |-> push)
    else $error("Conversions are not sixteen clocks apart.");
  // A full buffer must never take another word, or a held word would be overwritten.
  chk_full_no_push: assert property (buffer_full |-> !push)
    else $error("Word pushed into a full buffer.");
  chk_track_one_cycle: assert property (track_out |=> !track_out)
    else $error("Tracking lasted more than one cycle.");

  cov_first_word: cover property (state == sar_adc_pkg::ST_IDLE && enable ##[1:20] push);
  cov_buffer_fills: cover property (buffer_full && state == sar_adc_pkg::ST_LOAD);
  cov_back_to_back: cover property (push ##16 push);
  cov_abort_mid: cover property (state == sar_adc_pkg::ST_CONVERT && !enable);
  cov_stall_release: cover property (buffer_full ##1 data_ready);

endmodule
`default_nettype wire

// [rtl/sar_adc_pkg.sv]
// Purpose: Shared constants and types for the converter sequencer.
// Assumes: One clock at 25 MHz, synchronous active-high reset.
// Notes:   A conversion frame is sixteen clock periods long unless a full output buffer holds the load state.
package sar_adc_pkg;

  localparam int unsigned            RESULT_WIDTH   = 12;
  localparam int unsigned            FRAME_CYCLES   = 16;
  localparam int unsigned            CLK_PERIOD_NS  = 40;
  localparam int unsigned            BUF_DEPTH      = 2;
  localparam logic [3:0]             MSB_INDEX      = 4'hB;
  localparam logic [11:0]            FIRST_TRIAL    = 12'h800;
  localparam logic [11:0]            RESULT_RESET   = 12'h000;
  localparam logic [1:0]             COUNT_RESET    = 2'h0;
  localparam logic [1:0]             COUNT_FULL     = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TRACK   = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b011,
    ST_LOAD    = 3'b100,
    ST_RESTORE = 3'b101
  } seq_state_type;

  typedef struct packed {
    logic neg_single;
    logic pos_single;
    logic differential;
  } input_mode_type;

  localparam input_mode_type MODE_RESET = 3'b001;

  typedef struct packed {
    logic [11:0] code;
  } sample_word_type;

endpackage

// [test/sar_adc_far_side.sv]
// Purpose: Behavioural analog front end with comparator for the converter sequencer.
// Assumes: Analog levels are given as 12-bit codes of full scale.
// Notes:   Differential level is (pos - neg) / 2 around mid scale.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_far_side (
  input  wire logic                        [11:0] dac_code,
  input  wire sar_adc_pkg::input_mode_type input_mode,
  input  wire logic                        [11:0] analog_in_noninverting,
  input  wire logic                        [11:0] analog_in_inverting,
  output var  logic                        comp_in
);
  logic [12:0] diff_level;
  logic [11:0] level;
  assign diff_level = {1'b0, analog_in_noninverting} - {1'b0, analog_in_inverting} + 13'h1000;
  assign level = input_mode.neg_single ? analog_in_inverting :
                 input_mode.pos_single ? analog_in_noninverting : diff_level[12:1];
  assign comp_in = (level >= dac_code);
endmodule
`default_nettype wire

// [test/tb_sar_adc_digital_interface.sv]
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Far side answers by a live comparator.
// Notes:   Expected codes are queued at each sample.
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_digital_interface;
  logic clk_sys, sys_rst, enable, neg_input_single_sel, pos_input_single_sel, comp_in, out_ready;
  logic track_out, sample_out, data_ready, buffer_full, steady;
  logic [11:0] dac_code, result_word, ain_p, ain_n;
  logic [2:0] exp_mode;
  sar_adc_pkg::input_mode_type input_mode;
  int miscompares, checks, exp_code, last_dr, cyc, ndr, snap, q[$];
  sar_adc_digital_interface sar_adc_digital_interface_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .enable(enable), .neg_input_single_sel(neg_input_single_sel), .pos_input_single_sel(pos_input_single_sel),
    .comp_in(comp_in), .out_ready(out_ready), .track_out(track_out), .sample_out(sample_out),
    .input_mode(input_mode), .dac_code(dac_code), .result_word(result_word), .data_ready(data_ready),
    .buffer_full(buffer_full));
  sar_adc_far_side sar_adc_far_side_inst (.dac_code(dac_code), .input_mode(input_mode),
    .analog_in_noninverting(ain_p), .analog_in_inverting(ain_n), .comp_in(comp_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (sample_out === 1'b1) q.push_back(exp_code);
    if (data_ready === 1'b1) begin
      ndr++;
      check(input_mode, exp_mode);
      if (q.size() == 0) check(1, 0);
      else check(result_word, q.pop_front());
      if (steady && last_dr >= 0) check(cyc - last_dr, 16);
      last_dr = cyc;
    end
  end
  // Starts one run in mode m: 0 differential, 1 inverting, 2 non-inverting.
  task automatic start(input int m, input logic rdy);
    int p, n, k;
    p = $urandom_range(4095);
    n = $urandom_range(4095);
    @(posedge clk_sys);
    ain_p <= 12'(p);
    ain_n <= 12'(n);
    neg_input_single_sel <= (m == 1);
    pos_input_single_sel <= (m == 2);
    exp_code = m == 1 ? n : m == 2 ? p : (p - n + 4096) / 2;
    exp_mode = m == 1 ? 3'h4 : m == 2 ? 3'h2 : 3'h1;
    last_dr = -1;
    steady = rdy;
    out_ready <= rdy;
    @(posedge clk_sys);
    enable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (track_out !== 1'b1 && k < 4);
    check(k <= 2, 1);
    @(posedge clk_sys);
    #1 check({track_out, sample_out}, 2'b01);
  endtask
  task automatic stop();
    @(posedge clk_sys);
    enable <= 1'b0;
    out_ready <= 1'b1;
    repeat (24) @(posedge clk_sys);
    q.delete();
  endtask
  initial begin
    {enable, neg_input_single_sel, pos_input_single_sel, out_ready, steady} = '0;
    {ain_p, ain_n, miscompares, checks, cyc, ndr} = '0;
    sys_rst = 1;
    void'($urandom(81));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 0;
    #1 check({data_ready, input_mode, result_word}, 16'h1000);
    for (int i = 0; i < 9; i++) begin
      start(i % 3, 1'b1);
      repeat (60) @(posedge clk_sys);
      check(ndr >= 3 * (i + 1), 1);
      stop();
      ndr = 3 * (i + 1);
    end
    start(0, 1'b0);
    snap = ndr;
    repeat (60) @(posedge clk_sys);
    #1 check({buffer_full, ndr == snap}, 2'b11);
    @(posedge clk_sys);
    out_ready <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(ndr >= snap + 2, 1);
    stop();
    start(2, 1'b1);
    repeat (5) @(posedge clk_sys);
    enable <= 1'b0;
    snap = ndr;
    repeat (30) @(posedge clk_sys);
    check(ndr, snap);
    final_report();
  end
  initial begin
    #(40 * 4000);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
